/* File: design/cvr_pkg.sv */
// constants, field layout and types shared by the comparator reference register bank
// assumes one 20 mhz system clock and a synchronous active-high reset
package cvr_pkg;

	////////////////////////////////////////////////////////////////////////////
	// widths
	localparam int CVR_BUS_W = 32;
	localparam int CVR_REG_W = 16;
	localparam int CVR_LEVEL_W = 7;
	localparam int CVR_ADDR_W = 2;
	localparam int CVR_BE_W = 4;
	localparam int CVR_NUM_REF = 2;

	////////////////////////////////////////////////////////////////////////////
	// register indices (word addresses, byte address is four times the index)
	localparam logic [1:0] CVR_IDX_CTRL_ONE = 2'h0;
	localparam logic [1:0] CVR_IDX_CTRL_TWO = 2'h1;
	localparam logic [1:0] CVR_IDX_STATUS = 2'h2;

	////////////////////////////////////////////////////////////////////////////
	// control word field positions
	localparam int CVR_BIT_POWER = 15;
	localparam int CVR_BIT_PIN_OE = 14;
	localparam int CVR_BIT_SUPPLY = 11;
	localparam int CVR_BIT_INSEL = 10;
	localparam int CVR_LEVEL_LSB = 0;

	// implemented bits: 15, 14, 11, 10 and 6..0
	localparam logic [15:0] CVR_CTRL_WMASK = 16'hcc7f;
	localparam logic [15:0] CVR_CTRL_RESET = 16'h0000;

	////////////////////////////////////////////////////////////////////////////
	// status word field positions
	localparam int CVR_STAT_SETTLING_LSB = 0;
	localparam int CVR_STAT_READY_LSB = 4;

	////////////////////////////////////////////////////////////////////////////
	// timing
	localparam int CVR_CLK_PERIOD_NS = 50;
	localparam int CVR_SETTLE_NS = 10000;
	localparam int CVR_SETTLE_CYCLES = (CVR_SETTLE_NS + CVR_CLK_PERIOD_NS - 1) / CVR_CLK_PERIOD_NS;

	////////////////////////////////////////////////////////////////////////////
	// types
	typedef enum logic [0:0]
	{
		CVR_BUS_IDLE = 1'b0,
		CVR_BUS_ANSWER = 1'b1
	} cvr_bus_state_t;

	typedef struct packed
	{
		cvr_bus_state_t bus;
		logic [CVR_BUS_W-1:0] rdata;
	} cvr_top_state_t;

	typedef struct packed
	{
		logic [CVR_REG_W-1:0] value;
	} cvr_word_state_t;

endpackage

/* File: design/cvr_word_if.sv */
// write strobe and readback of one control word between bus front end and word store
// assumes both ends run on the same clock
`timescale 1ns/1ps
interface cvr_word_if;
	logic wr_stb;
	logic [15:0] wr_data;
	logic [1:0] wr_be;
	logic [15:0] value;

	modport core
	(
		output wr_stb,
		output wr_data,
		output wr_be,
		input value
	);

	modport word
	(
		input wr_stb,
		input wr_data,
		input wr_be,
		output value
	);
endinterface

/* File: design/cvr_reg_word.sv */
// one reference control word: byte-lane merge, unimplemented bits masked, reset to zero
// assumes the write strobe is a single-cycle pulse from the bus front end
`timescale 1ns/1ps
module cvr_reg_word
	import cvr_pkg::*;
(
	// clock and reset
	input wire logic core_clk_in,
	input wire logic rst_in,
	// word access
	cvr_word_if.word acc
);

	cvr_word_state_t st_ff;
	cvr_word_state_t nxt_st;

	////////////////////////////////////////////////////////////////////////////
	always_comb
	begin
		nxt_st = st_ff;
		if (acc.wr_stb)
		begin
			if (acc.wr_be[0])
				nxt_st.value[7:0] = acc.wr_data[7:0];
			if (acc.wr_be[1])
				nxt_st.value[15:8] = acc.wr_data[15:8];
			// unimplemented positions never hold a one
			nxt_st.value = nxt_st.value & CVR_CTRL_WMASK;
		end
	end

	always_ff @(posedge core_clk_in)
	begin
		if (rst_in)
			st_ff <= '{value: CVR_CTRL_RESET};
		else
			st_ff <= nxt_st;
	end

	assign acc.value = st_ff.value & CVR_CTRL_WMASK;

endmodule

/* File: design/cvr_ref_chan.sv */
// one reference channel: decodes its control word into analog controls and times settling
// assumes the control word comes straight from a flip-flop store
`timescale 1ns/1ps
module cvr_ref_chan
	import cvr_pkg::*;
#(
	parameter int SETTLE_CYCLES = CVR_SETTLE_CYCLES
)
(
	// clock and reset
	input wire logic core_clk_in,
	input wire logic rst_in,
	// control word
	input wire logic [CVR_REG_W-1:0] ctrl_in,
	// analog controls
	output logic ref_power_enable_out,
	output logic ref_pin_output_enable_out,
	output logic ref_supply_source_select_out,
	output logic ref_input_select_out,
	output logic [CVR_LEVEL_W-1:0] ref_level_code_out,
	// state
	output logic settling_out,
	output logic ready_out
);

	localparam int CNT_W = $clog2(SETTLE_CYCLES + 1);
	localparam logic [CNT_W-1:0] CNT_LOAD = CNT_W'(SETTLE_CYCLES);

	typedef struct packed
	{
		logic [CVR_REG_W-1:0] last;
		logic [CNT_W-1:0] cnt;
	} cvr_chan_state_t;

	cvr_chan_state_t st_ff;
	cvr_chan_state_t nxt_st;
	logic changed;

	////////////////////////////////////////////////////////////////////////////
	always_comb
	begin
		nxt_st = st_ff;
		changed = (ctrl_in & CVR_CTRL_WMASK) != (st_ff.last & CVR_CTRL_WMASK);
		nxt_st.last = ctrl_in;
		// powered down: nothing to settle
		if (!ctrl_in[CVR_BIT_POWER])
			nxt_st.cnt = '0;
		else if (changed)
			nxt_st.cnt = CNT_LOAD;
		else if (st_ff.cnt != '0)
			nxt_st.cnt = st_ff.cnt - CNT_W'(1);
	end

	always_ff @(posedge core_clk_in)
	begin
		if (rst_in)
			st_ff <= '{last: CVR_CTRL_RESET, cnt: '0};
		else
			st_ff <= nxt_st;
	end

	////////////////////////////////////////////////////////////////////////////
	assign ref_power_enable_out = ctrl_in[CVR_BIT_POWER];
	assign ref_pin_output_enable_out = ctrl_in[CVR_BIT_PIN_OE];
	assign ref_supply_source_select_out = ctrl_in[CVR_BIT_SUPPLY];
	assign ref_input_select_out = ctrl_in[CVR_BIT_INSEL];
	assign ref_level_code_out = ctrl_in[CVR_LEVEL_LSB +: CVR_LEVEL_W];
	assign settling_out = st_ff.cnt != '0;
	assign ready_out = ctrl_in[CVR_BIT_POWER] && (st_ff.cnt == '0);

endmodule

/* File: design/cvr_regs_top.sv */
// comparator voltage reference register bank: avalon-mm slave, two control words, status
// assumes a single avalon master that holds its request until waitrequest is low
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
// Summary of operation
// - bit 15 powers reference up or down
// - bit 14 of word one drives pin one
// - bit 14 of word two drives pin two
// - bit 11 picks external or analog supply
// - bit 10 picks external pin or ladder
// - bits 6..0 pick code/128 of reference
// - bits 13..12, 9..7 ignore writes, read zero
module cvr_regs_top
	import cvr_pkg::*;
#(
	parameter int SETTLE_CYCLES = CVR_SETTLE_CYCLES
)
(
	// clock and reset
	input wire logic core_clk_in,
	input wire logic rst_in,
	// avalon-mm slave
	input wire logic [CVR_ADDR_W-1:0] avs_address_in,
	input wire logic avs_read_in,
	input wire logic avs_write_in,
	input wire logic [CVR_BUS_W-1:0] avs_writedata_in,
	input wire logic [CVR_BE_W-1:0] avs_byteenable_in,
	output logic [CVR_BUS_W-1:0] avs_readdata_out,
	output logic avs_waitrequest_out,
	// reference controls, index 0 is reference one
	output logic [CVR_NUM_REF-1:0] ref_power_enable_out,
	output logic [CVR_NUM_REF-1:0] ref_pin_output_enable_out,
	output logic [CVR_NUM_REF-1:0] ref_supply_source_select_out,
	output logic [CVR_NUM_REF-1:0] ref_input_select_out,
	output logic [CVR_NUM_REF-1:0][CVR_LEVEL_W-1:0] ref_level_code_out
);

	////////////////////////////////////////////////////////////////////////////
	// elaboration checks
	if (SETTLE_CYCLES < 1)
		$error("settle count must be at least one cycle");

	////////////////////////////////////////////////////////////////////////////
	// declarations
	cvr_top_state_t st_ff;
	cvr_top_state_t nxt_st;
	logic req;
	logic commit_wr;
	logic [CVR_NUM_REF-1:0][CVR_REG_W-1:0] ctrl_q;
	logic [CVR_NUM_REF-1:0] settling;
	logic [CVR_NUM_REF-1:0] ready;
	logic [CVR_BUS_W-1:0] status_word;
	logic [CVR_BUS_W-1:0] rd_word;
	logic [CVR_NUM_REF-1:0][CVR_ADDR_W-1:0] ctrl_idx;

	assign ctrl_idx[0] = CVR_IDX_CTRL_ONE;
	assign ctrl_idx[1] = CVR_IDX_CTRL_TWO;

	////////////////////////////////////////////////////////////////////////////
	// bus handshake
	// fixed one-cycle answer: waitrequest drops in the cycle after the request
	// is first seen, and the write lands only at the edge the master completes on
	assign req = avs_read_in || avs_write_in;
	assign avs_waitrequest_out = req && (st_ff.bus == CVR_BUS_IDLE);
	assign commit_wr = avs_write_in && (st_ff.bus == CVR_BUS_ANSWER);
	assign avs_readdata_out = st_ff.rdata;

	always_comb
	begin
		status_word = '0;
		status_word[CVR_STAT_SETTLING_LSB +: CVR_NUM_REF] = settling;
		status_word[CVR_STAT_READY_LSB +: CVR_NUM_REF] = ready;
	end

	// upper half of the data bus and unmapped words read as zero
	always_comb
	begin
		rd_word = '0;
		unique case (avs_address_in)
			CVR_IDX_CTRL_ONE: rd_word = {16'h0000, ctrl_q[0]};
			CVR_IDX_CTRL_TWO: rd_word = {16'h0000, ctrl_q[1]};
			CVR_IDX_STATUS: rd_word = status_word;
			default: rd_word = '0;
		endcase
	end

	always_comb
	begin
		nxt_st = st_ff;
		unique case (st_ff.bus)
			CVR_BUS_IDLE:
			begin
				if (req)
				begin
					nxt_st.bus = CVR_BUS_ANSWER;
					nxt_st.rdata = avs_read_in ? rd_word : '0;
				end
			end
			CVR_BUS_ANSWER:
			begin
				nxt_st.bus = CVR_BUS_IDLE;
			end
		endcase
	end

	always_ff @(posedge core_clk_in)
	begin
		if (rst_in)
			st_ff <= '{bus: CVR_BUS_IDLE, rdata: '0};
		else
			st_ff <= nxt_st;
	end

	////////////////////////////////////////////////////////////////////////////
	// per-reference word store and decode
	// status is read-only; writes to it and to unmapped words are dropped
	for (genvar i = 0; i < CVR_NUM_REF; i++)
	begin : g_ref
		cvr_word_if word_bus();

		assign word_bus.wr_stb = commit_wr && (avs_address_in == ctrl_idx[i]);
		assign word_bus.wr_data = avs_writedata_in[CVR_REG_W-1:0];
		assign word_bus.wr_be = avs_byteenable_in[1:0];
		assign ctrl_q[i] = word_bus.value;

		cvr_reg_word u_word
		(
			.core_clk_in(core_clk_in),
			.rst_in(rst_in),
			.acc(word_bus)
		);

		cvr_ref_chan #(
			.SETTLE_CYCLES(SETTLE_CYCLES)
		) u_chan
		(
			.core_clk_in(core_clk_in),
			.rst_in(rst_in),
			.ctrl_in(ctrl_q[i]),
			.ref_power_enable_out(ref_power_enable_out[i]),
			.ref_pin_output_enable_out(ref_pin_output_enable_out[i]),
			.ref_supply_source_select_out(ref_supply_source_select_out[i]),
			.ref_input_select_out(ref_input_select_out[i]),
			.ref_level_code_out(ref_level_code_out[i]),
			.settling_out(settling[i]),
			.ready_out(ready[i])
		);
	end

endmodule

/* File: tb/cvr_regs_chk.sv */
// port-level checker for the reference register bank
// assumes one clock and a synchronous active-high reset
`timescale 1ns/1ps
module cvr_regs_chk
	import cvr_pkg::*;
(
	input wire logic core_clk_in,
	input wire logic rst_in,
	input wire logic [CVR_ADDR_W-1:0] avs_address_in,
	input wire logic avs_read_in,
	input wire logic avs_write_in,
	input wire logic [CVR_BUS_W-1:0] avs_writedata_in,
	input wire logic [CVR_BE_W-1:0] avs_byteenable_in,
	input wire logic [CVR_BUS_W-1:0] avs_readdata_out,
	input wire logic avs_waitrequest_out,
	input wire logic [CVR_NUM_REF-1:0] ref_power_enable_out,
	input wire logic [CVR_NUM_REF-1:0] ref_pin_output_enable_out,
	input wire logic [CVR_NUM_REF-1:0] ref_supply_source_select_out,
	input wire logic [CVR_NUM_REF-1:0] ref_input_select_out,
	input wire logic [CVR_NUM_REF-1:0][CVR_LEVEL_W-1:0] ref_level_code_out
);
	default clocking cb @(posedge core_clk_in); endclocking
	default disable iff (rst_in);
	sequence s_hi(a);
		avs_write_in && !avs_waitrequest_out && avs_address_in == a && avs_byteenable_in[1];
	endsequence
	sequence s_lo(a);
		avs_write_in && !avs_waitrequest_out && avs_address_in == a && avs_byteenable_in[0];
	endsequence
	////////////////////////////////////////////////////////////////////////////
	AST_POWER: assert property (s_hi(2'h0) |=> ref_power_enable_out[0] == $past(avs_writedata_in[15]))
		else $error("power bit not stored");
	AST_PIN_ONE: assert property (s_hi(2'h0) |=> ref_pin_output_enable_out[0] == $past(avs_writedata_in[14]))
		else $error("pin one enable not stored");
	AST_PIN_TWO: assert property (s_hi(2'h1) |=> ref_pin_output_enable_out[1] == $past(avs_writedata_in[14]))
		else $error("pin two enable not stored");
	AST_SUPPLY: assert property (s_hi(2'h1) |=> ref_supply_source_select_out[1] == $past(avs_writedata_in[11]))
		else $error("supply select not stored");
	AST_INSEL: assert property (s_hi(2'h0) |=> ref_input_select_out[0] == $past(avs_writedata_in[10]))
		else $error("input select not stored");
	AST_LEVEL: assert property (s_lo(2'h1) |=> ref_level_code_out[1] == $past(avs_writedata_in[6:0]))
		else $error("level code not stored");
	AST_HOLD: assert property (!(avs_write_in && !avs_waitrequest_out) |=> $stable(ref_level_code_out))
		else $error("level changed without write");
	AST_UNIMPL: assert property (avs_read_in && !avs_waitrequest_out |-> (avs_readdata_out & 32'hffff3380) == 32'h0)
		else $error("unimplemented bits read nonzero");
	AST_RESET: assert property (disable iff (1'b0) rst_in |=> ref_power_enable_out == 2'h0
		&& ref_pin_output_enable_out == 2'h0 && ref_level_code_out == 14'h0) else $error("reset did not clear");
endmodule
bind cvr_regs_top cvr_regs_chk u_chk (.core_clk_in, .rst_in, .avs_address_in, .avs_read_in, .avs_write_in,
	.avs_writedata_in, .avs_byteenable_in, .avs_readdata_out, .avs_waitrequest_out, .ref_power_enable_out,
	.ref_pin_output_enable_out, .ref_supply_source_select_out, .ref_input_select_out, .ref_level_code_out);

/* File: tb/cvr_regs_top_tb.sv */
// self-checking bench for the reference register bank
// assumes the bound checker; short settle count keeps the run brief
`timescale 1ns/1ps
module cvr_regs_top_tb
	import cvr_pkg::*;
;
	logic core_clk_in = 1'b0, rst_in = 1'b1, avs_read_in = 1'b0, avs_write_in = 1'b0;
	logic [1:0] avs_address_in = 2'h0;
	logic [31:0] avs_writedata_in = 32'h0, avs_readdata_out, got;
	logic [3:0] avs_byteenable_in = 4'h0;
	logic avs_waitrequest_out;
	logic [1:0] ref_power_enable_out, ref_pin_output_enable_out, ref_supply_source_select_out, ref_input_select_out;
	logic [1:0][6:0] ref_level_code_out;
	logic [15:0] exp_w [2];
	int error_cnt = 0, check_count = 0, cyc = 0;
	logic [1:0] a;
	always #25 core_clk_in = ~core_clk_in;
	cvr_regs_top #(.SETTLE_CYCLES(4)) dut (.core_clk_in, .rst_in, .avs_address_in, .avs_read_in, .avs_write_in,
		.avs_writedata_in, .avs_byteenable_in, .avs_readdata_out, .avs_waitrequest_out, .ref_power_enable_out,
		.ref_pin_output_enable_out, .ref_supply_source_select_out, .ref_input_select_out, .ref_level_code_out);
	////////////////////////////////////////////////////////////////////////////
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		check_count++;
		if (g !== e)
		begin
			error_cnt++;
			$display("wrong value at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	// request held until waitrequest is sampled low at a rising edge
	task automatic bus(input logic w, input logic [1:0] ad, input logic [31:0] d, input logic [3:0] b);
		@(posedge core_clk_in);
		avs_address_in <= ad;
		avs_read_in <= !w;
		avs_write_in <= w;
		avs_writedata_in <= d;
		avs_byteenable_in <= b;
		do @(posedge core_clk_in); while (avs_waitrequest_out !== 1'b0);
		got = avs_readdata_out;
		avs_read_in <= 1'b0;
		avs_write_in <= 1'b0;
	endtask
	// lanes 2 and 3 carry nothing; only implemented bits store
	function automatic logic [15:0] merge(input logic [15:0] o, input logic [31:0] d, input logic [3:0] b);
		logic [15:0] m;
		m = {{8{b[1]}}, {8{b[0]}}} & 16'hcc7f;
		return (o & ~m) | (d[15:0] & m);
	endfunction
	task automatic wr_ref(input logic [1:0] ad, input logic [31:0] d, input logic [3:0] b);
		bus(1'b1, ad, d, b);
		if (ad < 2'h2)
			exp_w[ad] = merge(exp_w[ad], d, b);
	endtask
	task automatic check_ref(input logic [1:0] i);
		bus(1'b0, i, 32'h0, 4'h0);
		chk(got, {16'h0, exp_w[i]});
		chk(32'(ref_power_enable_out[i]), 32'(exp_w[i][15]));
		chk(32'(ref_pin_output_enable_out[i]), 32'(exp_w[i][14]));
		chk(32'(ref_supply_source_select_out[i]), 32'(exp_w[i][11]));
		chk(32'(ref_input_select_out[i]), 32'(exp_w[i][10]));
		chk(32'(ref_level_code_out[i]), 32'(exp_w[i][6:0]));
	endtask
	always @(posedge core_clk_in)
	begin
		cyc <= cyc + 1;
		if (cyc == 5000)
		begin
			error_cnt++;
			print_verdict();
		end
	end
	initial
	begin
		exp_w[0] = 16'h0;
		exp_w[1] = 16'h0;
		void'($urandom(32'h37eb));
		repeat (6) @(posedge core_clk_in);
		rst_in <= 1'b0;
		check_ref(2'h0);
		check_ref(2'h1);
		$display("test reset done");
		wr_ref(2'h0, 32'hffffffff, 4'hf);
		check_ref(2'h0);
		wr_ref(2'h1, 32'hffffffff, 4'h1);
		check_ref(2'h1);
		wr_ref(2'h0, 32'h0, 4'h2);
		check_ref(2'h0);
		$display("test corners done");
		repeat (40)
		begin
			a = 2'($urandom % 2);
			wr_ref(a, $urandom, 4'($urandom));
			check_ref(a);
		end
		$display("test random done");
		wr_ref(2'h3, 32'hffffffff, 4'hf);
		wr_ref(2'h2, 32'hffffffff, 4'hf);
		bus(1'b0, 2'h3, 32'h0, 4'h0);
		chk(got, 32'h0);
		check_ref(2'h0);
		check_ref(2'h1);
		$display("test unmapped done");
		wr_ref(2'h1, 32'hcc7f, 4'h3);
		rst_in <= 1'b1;
		repeat (2) @(posedge core_clk_in);
		rst_in <= 1'b0;
		exp_w[0] = 16'h0;
		exp_w[1] = 16'h0;
		check_ref(2'h0);
		check_ref(2'h1);
		$display("test second reset done");
		// power-up of reference one starts settling, then reports ready
		wr_ref(2'h0, 32'h8000, 4'h3);
		bus(1'b0, 2'h2, 32'h0, 4'h0);
		chk(got, 32'h1 << CVR_STAT_SETTLING_LSB);
		repeat (8) @(posedge core_clk_in);
		bus(1'b0, 2'h2, 32'h0, 4'h0);
		chk(got, 32'h1 << CVR_STAT_READY_LSB);
		check_ref(2'h0);
		$display("test status done");
		print_verdict();
	end
endmodule
